// ===== rtl/edw_top.sv
// external data move sequencer with AHB-Lite register access
//
// The address map and the AHB-Lite interface to the registers were decided locally.
`timescale 1ns/1ps
// Function
// - fetch cycle first, then access cycle
// - stretch from three low control bits
// - stretch 0..7 gives 2..9 cycles
// - strobe 2 clocks, else 4 per step
// - only the data move is lengthened
// - stretch resets to one
// - hold input works only when enabled
// - with hold, stretch is minimum length
// - hold sampled at third state
// - sampled hold inserts one wait cycle
// - unlimited waits, released by other party
// - hold enable writes need timed unlock
// - address from pointer or register pair
// - pointer select bit zero, rest zero
module edw_top #(
    parameter int unsigned TA_WINDOW = edw_pkg::TA_WINDOW_CLK
) (
    input  wire logic              hclk,
    input  wire logic              hresetn,
    input  wire logic              hsel,
    input  wire logic [31:0]       haddr,
    input  wire logic [1:0]        htrans,
    input  wire logic              hwrite,
    input  wire logic [2:0]        hsize,
    input  wire logic [31:0]       hwdata,
    input  wire logic              hready,
    output logic                   hreadyout,
    output logic                   hresp,
    output logic [31:0]            hrdata,
    input  wire logic              hold_n,
    input  wire logic [7:0]        ext_din,
    output edw_pkg::edw_ext_s      ext,
    output logic                   move_done
);
    import edw_pkg::*;

    // ========================================================================
    // bus data phase tracking
    logic        dph_wr_r;
    logic        dph_rd_r;
    logic [7:0]  dph_idx_r;
    logic        dph_map_r;
    logic        rd_done_r;
    logic [31:0] hrdata_r;
    logic        a_valid;
    logic        wr_en;

    assign a_valid = hsel && htrans[1] && hready;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            dph_wr_r  <= 1'b0;
            dph_rd_r  <= 1'b0;
            dph_idx_r <= 8'h00;
            dph_map_r <= 1'b0;
        end else if (hready) begin
            dph_wr_r  <= a_valid && hwrite;
            dph_rd_r  <= a_valid && !hwrite;
            dph_idx_r <= haddr[9:2];
            dph_map_r <= (haddr[31:10] == 22'h000000) && (haddr[1:0] == 2'h0)
                         && (hsize == 3'h2);
        end
    end

    // reads take one wait state so a write just before is always seen
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            rd_done_r <= 1'b0;
        end else begin
            rd_done_r <= dph_rd_r && !rd_done_r;
        end
    end

    assign hreadyout = !dph_rd_r || rd_done_r;
    assign hresp     = 1'b0;
    assign wr_en     = dph_wr_r && dph_map_r;

    // ========================================================================
    // software registers
    edw_stretch_t stretch_r;
    logic         hold_en_r;
    logic         psel_r;
    logic [15:0]  dp0_r;
    logic [15:0]  dp1_r;
    logic [7:0]   wreg_r;
    logic [7:0]   p2_r;
    logic [7:0]   wdat_r;
    logic         ta_armed_r;
    logic [7:0]   ta_cnt_r;
    logic         ta_open;

    assign ta_open = (ta_cnt_r != 8'h00);

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            stretch_r <= STRETCH_RST;
        end else if (wr_en && (dph_idx_r == IDX_CLKCTL)) begin
            stretch_r <= hwdata[STRETCH_LSB +: STRETCH_W];
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hold_en_r <= 1'b0;
        end else if (wr_en && (dph_idx_r == IDX_HOLDCTL) && ta_open) begin
            hold_en_r <= hwdata[HOLD_EN_BIT];
        end
    end

    // unlock: first key then second key opens a short write window
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ta_armed_r <= 1'b0;
            ta_cnt_r   <= 8'h00;
        end else if (wr_en && (dph_idx_r == IDX_TIMED)) begin
            ta_armed_r <= (hwdata[7:0] == TA_KEY1);
            ta_cnt_r   <= (ta_armed_r && (hwdata[7:0] == TA_KEY2)) ? 8'(TA_WINDOW) : 8'h00;
        end else if (ta_open) begin
            ta_cnt_r   <= ta_cnt_r - 8'h01;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            psel_r <= 1'b0;
        end else if (wr_en && (dph_idx_r == IDX_PSEL)) begin
            psel_r <= hwdata[PSEL_BIT];
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            dp0_r  <= 16'h0000;
            dp1_r  <= 16'h0000;
            wreg_r <= 8'h00;
            p2_r   <= 8'hff;
            wdat_r <= 8'h00;
        end else if (wr_en) begin
            unique case (dph_idx_r)
                IDX_DPTR0: dp0_r  <= hwdata[15:0];
                IDX_DATA_POINTER_1: dp1_r  <= hwdata[15:0];
                IDX_WREG:  wreg_r <= hwdata[7:0];
                IDX_PORT2: p2_r   <= hwdata[7:0];
                IDX_WDATA: wdat_r <= hwdata[7:0];
                default: ;
            endcase
        end
    end

    // ========================================================================
    // move request
    logic        busy;
    logic        start;
    logic [7:0]  seq_rdata;
    logic [7:0]  mc_count;
    edw_req_s    req;

    // commands while busy are dropped; software polls the busy bit
    assign start = wr_en && (dph_idx_r == IDX_CMD) && hwdata[CMD_GO_BIT] && !busy;

    always_comb begin
        req         = '0;
        req.addr    = hwdata[CMD_IND_BIT] ? {p2_r, wreg_r} : (psel_r ? dp1_r : dp0_r);
        req.write   = hwdata[CMD_WR_BIT];
        req.wdata   = wdat_r;
        req.stretch = stretch_r;
        req.hold_en = hold_en_r;
    end

    edw_seq u_seq (
        .hclk     (hclk),
        .hresetn  (hresetn),
        .start    (start),
        .req      (req),
        .hold_n   (hold_n),
        .ext_din  (ext_din),
        .ext      (ext),
        .busy     (busy),
        .done     (move_done),
        .rdata    (seq_rdata),
        .mc_count (mc_count)
    );

    // ========================================================================
    // read data
    logic [31:0] rd_mux;

    always_comb begin
        rd_mux = 32'h00000000;
        if (dph_map_r) begin
            unique case (dph_idx_r)
                IDX_STATUS:  rd_mux = {16'h0000, mc_count, 7'h00, busy};
                IDX_DPTR0:   rd_mux = {16'h0000, dp0_r};
                IDX_DATA_POINTER_1:   rd_mux = {16'h0000, dp1_r};
                IDX_WREG:    rd_mux = {24'h000000, wreg_r};
                IDX_PORT2:   rd_mux = {24'h000000, p2_r};
                IDX_PSEL:    rd_mux = {31'h00000000, psel_r};
                IDX_WDATA:   rd_mux = {24'h000000, wdat_r};
                IDX_RDATA:   rd_mux = {24'h000000, seq_rdata};
                IDX_HOLDCTL: rd_mux = {24'h000000, hold_en_r, 7'h00};
                IDX_CLKCTL:  rd_mux = {29'h00000000, stretch_r};
                default:     rd_mux = 32'h00000000;
            endcase
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hrdata_r <= 32'h00000000;
        end else if (dph_rd_r && !rd_done_r) begin
            hrdata_r <= rd_mux;
        end
    end

    assign hrdata = hrdata_r;

    // ========================================================================
    // checks
    a_hold_locked: assert property (@(posedge hclk) disable iff (!hresetn)
        (wr_en && (dph_idx_r == IDX_HOLDCTL) && !ta_open) |=> $stable(hold_en_r))
        else $error("hold enable changed without unlock");

    a_psel_upper_zero: assert property (@(posedge hclk) disable iff (!hresetn)
        (dph_rd_r && !rd_done_r && dph_map_r && (dph_idx_r == IDX_PSEL)) |=>
        (hrdata_r[31:1] == 31'h00000000))
        else $error("pointer select upper bits not zero");

    a_ptr_addr: assert property (@(posedge hclk) disable iff (!hresetn)
        (start && !hwdata[CMD_IND_BIT]) |=> (ext.addr == (psel_r ? dp1_r : dp0_r)))
        else $error("move address not from selected pointer");

    a_read_waits_one: assert property (@(posedge hclk) disable iff (!hresetn)
        (dph_rd_r && !rd_done_r) |-> !hreadyout ##1 hreadyout)
        else $error("read data phase not one wait state");

endmodule : edw_top

// ===== rtl/edw_pkg.sv
// shared constants, types and register map of the external data move sequencer
package edw_pkg;

    // ========================================================================
    // machine cycle timing
    localparam int unsigned  STATES_PER_MC = 4;
    localparam logic [1:0]   PH_C1         = 2'h0;
    localparam logic [1:0]   PH_C3         = 2'h2;
    localparam logic [1:0]   PH_C4         = 2'h3;

    // ========================================================================
    // register indices, byte address is four times the index
    localparam logic [7:0]   IDX_CMD       = 8'h80;
    localparam logic [7:0]   IDX_STATUS    = 8'h81;
    localparam logic [7:0]   IDX_DPTR0     = 8'h82;
    localparam logic [7:0]   IDX_DATA_POINTER_1     = 8'h83;
    localparam logic [7:0]   IDX_WREG      = 8'h84;
    localparam logic [7:0]   IDX_PORT2     = 8'h85;
    localparam logic [7:0]   IDX_PSEL      = 8'h86;
    localparam logic [7:0]   IDX_WDATA     = 8'h87;
    localparam logic [7:0]   IDX_RDATA     = 8'h88;
    localparam logic [7:0]   IDX_HOLDCTL   = 8'h89;
    localparam logic [7:0]   IDX_TIMED     = 8'h8a;
    localparam logic [7:0]   IDX_CLKCTL    = 8'h8b;

    // ========================================================================
    // field positions and reset values
    localparam int unsigned  STRETCH_LSB   = 0;
    localparam int unsigned  STRETCH_W     = 3;
    localparam int unsigned  HOLD_EN_BIT   = 7;
    localparam int unsigned  PSEL_BIT      = 0;
    localparam int unsigned  CMD_GO_BIT    = 0;
    localparam int unsigned  CMD_WR_BIT    = 1;
    localparam int unsigned  CMD_IND_BIT   = 2;
    localparam int unsigned  ST_BUSY_BIT   = 0;
    localparam int unsigned  ST_MC_LSB     = 8;
    localparam logic [2:0]   STRETCH_RST   = 3'h1;
    localparam logic [7:0]   TA_KEY1       = 8'haa;
    localparam logic [7:0]   TA_KEY2       = 8'h55;
    localparam int unsigned  TA_WINDOW_CLK = 12;

    // ========================================================================
    // types
    typedef logic [2:0] edw_stretch_t;

    typedef enum logic [2:0] {
        EDW_IDLE   = 3'b001,
        EDW_FETCH  = 3'b010,
        EDW_ACCESS = 3'b100
    } edw_state_e;

    typedef struct packed {
        logic [15:0]  addr;
        logic         write;
        logic [7:0]   wdata;
        edw_stretch_t stretch;
        logic         hold_en;
    } edw_req_s;

    typedef struct packed {
        logic [15:0] addr;
        logic        rd_n;
        logic        wr_n;
        logic [7:0]  dout;
        logic        doe;
    } edw_ext_s;

endpackage : edw_pkg

// ===== rtl/edw_seq.sv
// machine cycle sequencer for one external data move
`timescale 1ns/1ps
module edw_seq (
    input  wire logic              hclk,
    input  wire logic              hresetn,
    input  wire logic              start,
    input  wire edw_pkg::edw_req_s req,
    input  wire logic              hold_n,
    input  wire logic [7:0]        ext_din,
    output edw_pkg::edw_ext_s      ext,
    output logic                   busy,
    output logic                   done,
    output logic [7:0]             rdata,
    output logic [7:0]             mc_count
);
    import edw_pkg::*;

    edw_state_e  state_r;
    logic [1:0]  phase_r;
    logic [2:0]  acc_r;
    logic        ext_r;
    logic        strobe_r;
    logic        done_r;
    logic [7:0]  rdata_r;
    logic [7:0]  mc_r;
    edw_req_s    req_r;
    logic        last;
    logic        wait_now;
    logic        in_acc;
    logic        strobe_set;
    logic        strobe_clr;

    assign in_acc     = (state_r == EDW_ACCESS);
    assign last       = (acc_r == req_r.stretch);
    assign wait_now   = req_r.hold_en && !hold_n;
    assign strobe_set = in_acc && (acc_r == 3'h0)
                        && (phase_r == ((req_r.stretch == 3'h0) ? PH_C1 : PH_C3));
    assign strobe_clr = in_acc && (phase_r == PH_C3) && last && !wait_now;

    // ========================================================================
    // request capture
    // settings frozen
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            req_r <= '0;
        end else if (start && (state_r == EDW_IDLE)) begin
            req_r <= req;
        end
    end

    // ========================================================================
    // state and phase
    // fetch then access
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            state_r <= EDW_IDLE;
            phase_r <= PH_C1;
            acc_r   <= 3'h0;
        end else begin
            unique case (state_r)
                EDW_IDLE: begin
                    phase_r <= PH_C1;
                    acc_r   <= 3'h0;
                    if (start) begin
                        state_r <= EDW_FETCH;
                    end
                end
                EDW_FETCH: begin
                    phase_r <= phase_r + 2'h1;
                    if (phase_r == PH_C4) begin
                        state_r <= EDW_ACCESS;
                    end
                end
                EDW_ACCESS: begin
                    phase_r <= phase_r + 2'h1;
                    if (phase_r == PH_C4) begin
                        if (last && !ext_r) begin
                            state_r <= EDW_IDLE;
                        end else if (!last) begin
                            acc_r <= acc_r + 3'h1;
                        end
                    end
                end
            endcase
        end
    end

    // ========================================================================
    // hold-off sampling
    // sample at third_state
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ext_r <= 1'b0;
        end else begin
            ext_r <= in_acc && (phase_r == PH_C3) && last && wait_now;
        end
    end

    // ========================================================================
    // strobe, read capture, completion
    // strobe width
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            strobe_r <= 1'b0;
        end else if (strobe_clr) begin
            strobe_r <= 1'b0;
        end else if (strobe_set) begin
            strobe_r <= 1'b1;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            rdata_r <= 8'h00;
        end else if (strobe_clr && !req_r.write) begin
            rdata_r <= ext_din;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            done_r <= 1'b0;
        end else begin
            done_r <= in_acc && (phase_r == PH_C4) && last && !ext_r;
        end
    end

    // whole move length in machine cycles, saturating
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            mc_r <= 8'h00;
        end else if (start && (state_r == EDW_IDLE)) begin
            mc_r <= 8'h00;
        end else if ((state_r != EDW_IDLE) && (phase_r == PH_C4) && (mc_r != 8'hff)) begin
            mc_r <= mc_r + 8'h01;
        end
    end

    assign ext.addr  = req_r.addr;
    assign ext.rd_n  = !(strobe_r && !req_r.write);
    assign ext.wr_n  = !(strobe_r && req_r.write);
    assign ext.dout  = req_r.wdata;
    assign ext.doe   = (state_r != EDW_IDLE) && req_r.write;
    assign busy      = (state_r != EDW_IDLE);
    assign done      = done_r;
    assign rdata     = rdata_r;
    assign mc_count  = mc_r;

    // ========================================================================
    // checks
    logic [4:0] width_r;
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            width_r <= 5'h00;
        end else if (strobe_r) begin
            width_r <= width_r + 5'h01;
        end else begin
            width_r <= 5'h00;
        end
    end

    sequence s_fetch;
        (state_r == EDW_FETCH) [*4];
    endsequence

    sequence s_access_begin;
        (state_r == EDW_ACCESS) && (acc_r == 3'h0) && (phase_r == PH_C1);
    endsequence

    a_fetch_then_access: assert property (@(posedge hclk) disable iff (!hresetn)
        (start && (state_r == EDW_IDLE)) |=> s_fetch ##1 s_access_begin)
        else $error("access did not follow a four clock fetch");

    a_strobe_width: assert property (@(posedge hclk) disable iff (!hresetn)
        ($fell(strobe_r) && !req_r.hold_en) |->
        (width_r == ((req_r.stretch == 3'h0) ? 5'd2 : {req_r.stretch, 2'b00})))
        else $error("strobe width does not match stretch");

    a_stretch0_strobe: assert property (@(posedge hclk) disable iff (!hresetn)
        ($rose(strobe_r) && (req_r.stretch == 3'h0) && !req_r.hold_en) |->
        strobe_r [*2] ##1 !strobe_r)
        else $error("stretch zero strobe not two clocks");

    a_move_length: assert property (@(posedge hclk) disable iff (!hresetn)
        (done_r && !req_r.hold_en) |-> (mc_r == ({5'h00, req_r.stretch} + 8'd2)))
        else $error("move length wrong for stretch");

    a_no_hold_off: assert property (@(posedge hclk) disable iff (!hresetn)
        (!req_r.hold_en && in_acc && (phase_r == PH_C4) && last) |=> done_r)
        else $error("move extended while hold disabled");

    a_hold_extends: assert property (@(posedge hclk) disable iff (!hresetn)
        (in_acc && (phase_r == PH_C3) && last && wait_now) |=>
        (strobe_r && !done_r) ##1 (strobe_r && in_acc))
        else $error("hold-off did not extend the access");

    a_addr_stable: assert property (@(posedge hclk) disable iff (!hresetn)
        (busy && $past(busy)) |-> ($stable(ext.addr) && $stable(req_r.stretch)))
        else $error("address or stretch changed during move");

    a_read_capture: assert property (@(posedge hclk) disable iff (!hresetn)
        ($rose(ext.rd_n)) |-> (rdata_r == $past(ext_din)))
        else $error("read data not captured at strobe rise");

endmodule : edw_seq

// ===== test/edw_mem_model.sv
// external data memory model facing the data move sequencer
`timescale 1ns/1ps
module edw_mem_model
    import edw_pkg::*;
(
    input  wire logic        hclk,
    input  wire logic        hresetn,
    input  edw_ext_s         ext,
    input  wire logic [7:0]  hold_mc,
    output logic             hold_n,
    output logic [7:0]       ext_din,
    output logic [15:0]      last_addr
);
    // ========================================================================
    // storage and strobe tracking
    logic [7:0] mem [0:65535];
    logic [7:0] last_q;
    logic [9:0] cnt;
    logic       strobe;

    initial begin
        for (int i = 0; i < 65536; i++) begin
            mem[i] = i[7:0] ^ 8'h5a;
        end
    end

    assign strobe = !ext.rd_n || !ext.wr_n;
    // hold released after hold_mc machine cycles of strobe
    assign hold_n = !(strobe && cnt < {hold_mc, 2'h0});
    // undriven bus shows the inverse of the last byte, not a stale copy
    assign ext_din = ext.rd_n ? ~last_q : mem[ext.addr];

    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            cnt       <= 10'h0;
            last_q    <= 8'h0;
            last_addr <= 16'h0;
        end else begin
            cnt <= strobe ? cnt + 10'h1 : 10'h0;
            if (!ext.rd_n) last_q <= mem[ext.addr];
            if (strobe) last_addr <= ext.addr;
            if (!ext.wr_n) mem[ext.addr] <= ext.dout;
        end
    end
endmodule : edw_mem_model

// ===== test/edw_top_tb.sv
// self-checking bench for the external data move sequencer
`timescale 1ns/1ps
module edw_top_tb;
    import edw_pkg::*;
    logic hclk, hresetn, hsel, hwrite, hready, hreadyout, hresp, hold_n, move_done;
    logic [31:0] haddr, hwdata, hrdata, rd_cap;
    logic [1:0]  htrans;
    logic [2:0]  hsize;
    logic [7:0]  ext_din, hold_mc;
    logic [15:0] last_addr;
    edw_ext_s    ext;
    int err_count, num_checks, e_cnt, s_cnt;

    assign hready = hreadyout;
    edw_top #(.TA_WINDOW(12)) dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
        .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .hold_n(hold_n),
        .ext_din(ext_din), .ext(ext), .move_done(move_done));
    edw_mem_model mdl (.hclk(hclk), .hresetn(hresetn), .ext(ext), .hold_mc(hold_mc),
        .hold_n(hold_n), .ext_din(ext_din), .last_addr(last_addr));

    initial begin
        hclk = 1'b0;
        forever #2 hclk = ~hclk;
    end

    always @(posedge hclk) begin
        e_cnt++;
        if (!ext.rd_n || !ext.wr_n) s_cnt++;
    end

    // ========================================================================
    // reporting
    task print_verdict;
        $display("checks %0d mismatches %0d", num_checks, err_count);
        if (err_count == 0 && num_checks > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask : print_verdict

    task chk(input logic [31:0] exp, input logic [31:0] got);
        num_checks++;
        if (got !== exp) begin
            err_count++;
            $display("unexpected at %0t: exp %h got %h", $time, exp, got);
        end
    endtask : chk

    // ========================================================================
    // bus master
    function automatic logic [31:0] ra(input logic [7:0] i);
        return {22'h0, i, 2'h0};
    endfunction : ra

    // ready and read data are taken at the rising edge, before the design updates
    task wait_ready;
        int n;
        n = 0;
        @(posedge hclk);
        while (hreadyout !== 1'b1 && n < 100) begin
            n++;
            @(posedge hclk);
        end
        rd_cap = hrdata;
        if (n >= 100) begin
            err_count++;
            print_verdict();
        end
    endtask : wait_ready

    task ahb(input logic w, input logic [31:0] a, input logic [31:0] wd);
        hsel   <= 1'b1;
        haddr  <= a;
        htrans <= 2'b10;
        hwrite <= w;
        wait_ready();
        htrans <= 2'b00;
        hwdata <= wd;
        wait_ready();
    endtask : ahb

    task wr(input logic [7:0] i, input logic [31:0] v);
        ahb(1'b1, ra(i), v);
    endtask : wr

    task rd_chk(input logic [31:0] a, input logic [31:0] exp);
        ahb(1'b0, a, 32'h0);
        chk(exp, rd_cap);
    endtask : rd_chk

    // ========================================================================
    // data moves
    task start(input logic w, input logic ind);
        wr(IDX_CMD, {29'h0, ind, w, 1'b1});
        @(negedge hclk);
        e_cnt = 0;
        s_cnt = 0;
        @(posedge hclk);
    endtask : start

    task finish(input int s, input int n, input logic [15:0] a, input logic w);
        int mc;
        int k;
        mc = 2 + s + n;
        k = 0;
        while (move_done !== 1'b1 && k < 2000) begin
            k++;
            @(negedge hclk);
        end
        if (k >= 2000) begin
            err_count++;
            print_verdict();
        end
        // counts are read in the done cycle, before the edge that ends it
        chk(4 * mc, e_cnt);
        chk((s == 0 ? 2 : 4 * s) + 4 * n, s_cnt);
        chk({16'h0, a}, {16'h0, last_addr});
        @(posedge hclk);
        rd_chk(ra(IDX_STATUS), {16'h0, mc[7:0], 8'h0});
        if (w) chk(32'ha5, {24'h0, mdl.mem[a]});
        else rd_chk(ra(IDX_RDATA), {24'h0, mdl.mem[a]});
    endtask : finish

    // ========================================================================
    // main sequence
    initial begin
        {hsel, hwrite, haddr, hwdata, htrans} = '0;
        hsize = 3'h2;
        hold_mc = 8'h2;
        hresetn = 1'b0;
        err_count = 0;
        num_checks = 0;
        repeat (8) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        rd_chk(ra(IDX_CLKCTL), 32'h1);
        rd_chk(ra(IDX_HOLDCTL), 32'h0);
        rd_chk(32'h400, 32'h0);
        wr(IDX_PSEL, 32'hff);
        rd_chk(ra(IDX_PSEL), 32'h1);
        wr(IDX_DPTR0, 32'h1234);
        wr(IDX_DATA_POINTER_1, 32'h5678);
        wr(IDX_WREG, 32'h9a);
        wr(IDX_PORT2, 32'hbc);
        wr(IDX_WDATA, 32'ha5);
        // hold pulled low but disabled: no waits expected
        for (int s = 0; s < 8; s++) begin
            wr(IDX_CLKCTL, s);
            wr(IDX_PSEL, s & 1);
            start(s[0], 1'b0);
            finish(s, 0, s[0] ? 16'h5678 : 16'h1234, s[0]);
        end
        wr(IDX_CLKCTL, 32'h3);
        start(1'b0, 1'b1);
        wr(IDX_CLKCTL, 32'h0);
        // busy, and only the fetch cycle counted so far
        rd_chk(ra(IDX_STATUS), 32'h101);
        finish(3, 0, 16'hbc9a, 1'b0);
        start(1'b0, 1'b1);
        finish(0, 0, 16'hbc9a, 1'b0);
        wr(IDX_HOLDCTL, 32'h80);
        rd_chk(ra(IDX_HOLDCTL), 32'h0);
        wr(IDX_TIMED, 32'haa);
        wr(IDX_TIMED, 32'h55);
        wr(IDX_HOLDCTL, 32'h80);
        rd_chk(ra(IDX_HOLDCTL), 32'h80);
        start(1'b1, 1'b1);
        finish(0, 2, 16'hbc9a, 1'b1);
        wr(IDX_CLKCTL, 32'h1);
        hold_mc <= 8'h1;
        start(1'b0, 1'b0);
        finish(1, 1, 16'h5678, 1'b0);
        print_verdict();
    end
endmodule : edw_top_tb
